// *** controller_cycle_pin_interface_test.sv ***
// Purpose: self-checking bench of the cycle and pin core
// Assumes: inputs change by non-blocking assignment at the rising edge
// Notes: outputs are sampled at the falling edge, where they have settled
`timescale 1ns/1ns
module controller_cycle_pin_interface_test;
  // ==========================================================
  // signals
  logic core_clk, reset, nmi_n, int_n, halt_n, half_speed_request_n, si_pin;
  logic [12:0] prog_addr;
  logic [19:0] instr_in;
  logic [2:0] bank_sel_n;
  logic addr_out_flag, data_out_flag, io_bus_oe, master_strobe, q34_sync_clock;
  logic [7:0] io_bus_in, io_bus_out;
  logic user_flag_out, result_not_zero, intr_accept_out, carry_out_pin;
  int num_errors = 0;
  int num_checks = 0;
  int n0, n1;
  // one row: instruction at address i and the pins it should give in Q3
  typedef struct {
    logic [19:0] word;
    logic [2:0] bank_n;
    logic addr_flag;
    logic data_flag;
    logic oe;
    logic [7:0] bus;
    logic [12:0] next;
  } row_t;
  row_t rows [0:7];
  // ==========================================================
  // instances
  cycle_pin_core i_dut (.core_clk(core_clk), .reset(reset), .prog_addr(prog_addr), .instr_in(instr_in),
    .nmi_n(nmi_n), .int_n(int_n), .halt_n(halt_n), .half_speed_request_n(half_speed_request_n),
    .si_pin(si_pin), .bank_sel_n(bank_sel_n), .addr_out_flag(addr_out_flag), .data_out_flag(data_out_flag),
    .io_bus_in(io_bus_in), .io_bus_out(io_bus_out), .io_bus_oe(io_bus_oe), .master_strobe(master_strobe),
    .q34_sync_clock(q34_sync_clock), .user_flag_out(user_flag_out), .result_not_zero(result_not_zero),
    .intr_accept_out(intr_accept_out), .carry_out_pin(carry_out_pin));
  prog_io_model i_mem (.core_clk(core_clk), .prog_addr(prog_addr), .instr_in(instr_in), .bank_sel_n(bank_sel_n),
    .addr_out_flag(addr_out_flag), .data_out_flag(data_out_flag), .master_strobe(master_strobe),
    .io_bus_out(io_bus_out), .io_bus_oe(io_bus_oe), .io_bus_in(io_bus_in));
  // ==========================================================
  // helpers
  function automatic logic [19:0] xmit(input logic [7:0] imm, input logic [3:0] dst, input logic [1:0] bank,
    input logic dir);
    return {3'h4, imm, 2'h0, dst, bank, dir};
  endfunction : xmit
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // bounded wait for a given program address
  task automatic wait_pc(input logic [12:0] a);
    int n;
    n = 0;
    while (prog_addr !== a && n < 24) begin
      @(negedge core_clk);
      n++;
    end
    check(prog_addr, a);
  endtask : wait_pc
  // clocks that the strobe stays high in the next cycle
  task automatic strobe_len(output int n);
    int w;
    w = 0;
    n = 0;
    while (master_strobe !== 1'b1 && w < 24) begin
      @(negedge core_clk);
      w++;
    end
    while (master_strobe === 1'b1 && n < 24) begin
      @(negedge core_clk);
      n++;
    end
  endtask : strobe_len
  // reset for six clocks and look at the pins while it is held
  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    check({prog_addr, bank_sel_n, addr_out_flag, data_out_flag, io_bus_oe}, {13'h0, 3'b111, 3'b000});
    check(intr_accept_out, 1'b0);
    @(posedge core_clk);
    reset <= 1'b0;
  endtask : do_reset
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // ==========================================================
  // clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // the tests need about a hundred clocks; this is far beyond that
  initial begin
    #3000000;
    num_errors++;
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    // status input held high, so a sampled status bit differs from its reset value
    {reset, nmi_n, int_n, halt_n, half_speed_request_n, si_pin} = 6'b111111;
    for (int a = 0; a < 8192; a++) i_mem.rom[a] = 20'h00000;
    rows[0] = '{xmit(8'h5A, 4'hC, 2'h0, 1'b0), 3'b110, 1'b1, 1'b0, 1'b1, 8'hA5, 13'h0001};
    rows[1] = '{xmit(8'h3C, 4'hE, 2'h0, 1'b0), 3'b011, 1'b1, 1'b0, 1'b1, 8'hC3, 13'h0002};
    rows[2] = '{xmit(8'h81, 4'h1, 2'h2, 1'b1), 3'b101, 1'b0, 1'b1, 1'b1, 8'h7E, 13'h0003};
    rows[3] = '{xmit(8'h04, 4'hF, 2'h0, 1'b0), 3'b111, 1'b0, 1'b0, 1'b0, 8'h00, 13'h0004};
    // aux gets C8, add of reg C (5A) gives 22 with carry, then status goes out on bank A
    rows[4] = '{xmit(8'hC8, 4'h0, 2'h0, 1'b0), 3'b111, 1'b0, 1'b0, 1'b0, 8'h00, 13'h0005};
    rows[5] = '{{3'h1, 4'hC, 3'h0, 3'h7, 4'h1, 2'h0, 1'b0}, 3'b111, 1'b0, 1'b0, 1'b0, 8'h00, 13'h0006};
    // status 66: stack empty, status input, user flag, nonzero set, mask clear
    rows[6] = '{{3'h0, 4'hF, 3'h0, 3'h7, 4'h0, 2'h1, 1'b1}, 3'b110, 1'b0, 1'b1, 1'b1, 8'h99, 13'h0007};
    rows[7] = '{{3'h5, 4'h0, 13'h1FFF}, 3'b111, 1'b0, 1'b0, 1'b0, 8'h00, 13'h1FFF};
    for (int i = 0; i < 8; i++) i_mem.rom[i] = rows[i].word;
    i_mem.rom[13'h1FFF] = {3'h5, 4'h0, 13'h0004}; // top address jumps back to 4
    do_reset();
    // table: Q3 pins, then Q4 strobe, then the new address in Q1
    for (int i = 0; i < 8; i++) begin
      n0 = 0;
      @(negedge core_clk);
      while (!(q34_sync_clock === 1'b1 && master_strobe === 1'b0) && n0 < 20) begin
        @(negedge core_clk);
        n0++;
      end
      check(bank_sel_n, rows[i].bank_n);
      check({addr_out_flag, data_out_flag}, {rows[i].addr_flag, rows[i].data_flag});
      check(io_bus_oe, rows[i].oe);
      if (rows[i].oe) check(io_bus_out, rows[i].bus);
      check(prog_addr, i);
      @(negedge core_clk);
      check({master_strobe, q34_sync_clock}, 2'b11);
      @(negedge core_clk);
      check(prog_addr, rows[i].next);
      check({master_strobe, q34_sync_clock}, 2'b00);
    end
    check({user_flag_out, intr_accept_out}, 2'b11);
    check({result_not_zero, carry_out_pin}, 2'b11);
    check({i_mem.last_addr, i_mem.last_data}, {8'h3C, 8'h66});
    // maskable interrupt, then a non-maskable one while the mask is set
    @(posedge core_clk);
    int_n <= 1'b0;
    wait_pc(13'h0002);
    check(intr_accept_out, 1'b0);
    @(posedge core_clk);
    int_n <= 1'b1;
    nmi_n <= 1'b0;
    wait_pc(13'h0001);
    @(posedge core_clk);
    nmi_n <= 1'b1;
    // halt freezes the address and keeps the banks idle
    halt_n <= 1'b0;
    repeat (12) @(negedge core_clk);
    n1 = prog_addr;
    repeat (12) @(negedge core_clk);
    check(prog_addr, n1[12:0]);
    check(bank_sel_n, 3'b111);
    @(posedge core_clk);
    halt_n <= 1'b1;
    // slow request doubles each quarter; first cycle may be partial
    half_speed_request_n <= 1'b0;
    strobe_len(n0);
    strobe_len(n0);
    check(n0, 2);
    @(posedge core_clk);
    half_speed_request_n <= 1'b1;
    strobe_len(n1);
    strobe_len(n1);
    check(n1, 1);
    // reset in mid-run, then the program restarts from zero
    do_reset();
    wait_pc(13'h0001);
    stop_test();
  end
endmodule : controller_cycle_pin_interface_test

// *** cyc_defines.svh ***
// Purpose: shared constants for the instruction-cycle and pin interface core
// Assumes: one core clock period per quarter cycle at normal speed
// Notes: offsets of fields inside the 20-bit instruction word, status bits, vectors
//
// Operation
// - whole instruction done within one cycle, >=150ns
// - input, rotate, mask, ALU, rotate, merge, output
// - drive 13-bit program address, LSB lowest
// - accept 20-bit instruction word from program store
// - NMI raised on each falling NMI edge
// - INT sampled in Q4, pushes next address
// - one active-low bank select per peripheral bank
// - address flag high while address driven
// - data flag high while data driven
// - eight active-low three-state bus lines
// - master strobe high only in Q4
// - sync clock high in Q3 and Q4
// - halt sampled in Q1 skips the cycle
// - slow request in Q1 halves the rate
// - one quarter per input clock period
// - status input pin copied during Q4
// - user flag and nonzero pins from status
// - accept pin is mask clear and stack not full
// - carry register shown on carry pin
// - no bank selected floats bus; one at most
// - both flags low reads; never both high
`ifndef CYC_DEFINES_SVH
`define CYC_DEFINES_SVH

// ==========================================================
// timing
`define CYC_MIN_NS 150
`define CYC_CLK_NS 100
`define CYC_MIN_CLKS ((`CYC_MIN_NS + `CYC_CLK_NS - 1) / `CYC_CLK_NS)

// ==========================================================
// instruction word fields
`define F_OP 19:17
`define F_SRC 16:13
`define F_RROT 12:10
`define F_LEN 9:7
`define F_DST 6:3
`define F_IOBANK 2:1
`define F_IODIR 0
`define F_IMM 16:9
`define F_JADDR 12:0

// ==========================================================
// register addresses, status bits, vectors
`define REG_AUX 4'h0
`define REG_BANK_A 4'hC
`define REG_BANK_C 4'hE
`define REG_STATUS 4'hF
`define ST_MASK 0
`define ST_NOT_ZERO 1
`define ST_USER_FLAG 2
`define ST_UF0 3
`define ST_UF1 4
`define ST_SI 5
`define ST_SE 6
`define ST_STK_FULL 7
`define NMI_VEC 13'h0001
`define INT_VEC 13'h0002

`endif

// *** cyc_pkg.sv ***
// Purpose: types shared by the cycle timer and the pin interface core
// Assumes: nothing beyond SystemVerilog enums
// Notes: default encodings, counting up from zero in the listed order
package cyc_pkg;
  // ==========================================================
  // quarter of the instruction cycle
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;
  // instruction classes
  typedef enum logic [2:0] {OP_MOVE, OP_ADD, OP_AND, OP_XOR, OP_XMIT, OP_JMP, OP_CALL, OP_RET} op_t;
endpackage : cyc_pkg

// *** cycle_pin_core.sv ***
// Purpose: instruction-cycle sequencing and external pins of the bit-oriented controller
// Assumes: core_clk is the base clock; all pin inputs synchronous to it
// Notes: io bus is three signals; true data = ~io_bus_out when io_bus_oe
`timescale 1ns/1ns
`include "cyc_defines.svh"
module cycle_pin_core
  import cyc_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic [12:0] prog_addr,
  input wire logic [19:0] instr_in,
  input wire logic nmi_n,
  input wire logic int_n,
  input wire logic halt_n,
  input wire logic half_speed_request_n,
  input wire logic si_pin,
  output logic [2:0] bank_sel_n,
  output logic addr_out_flag,
  output logic data_out_flag,
  input wire logic [7:0] io_bus_in,
  output logic [7:0] io_bus_out,
  output logic io_bus_oe,
  output logic master_strobe,
  output logic q34_sync_clock,
  output logic user_flag_out,
  output logic result_not_zero,
  output logic intr_accept_out,
  output logic carry_out_pin
);
  localparam int SPW = $clog2(STACK_DEPTH + 1);

  // ==========================================================
  // state
  typedef struct packed {
    logic [12:0] pc; // program address
    logic [19:0] iword; // instruction latched at end of Q1
    logic run; // cycle not halted
    logic [7:0] in_data; // true-polarity data read from bus
    logic [7:0] out_q; // pin-polarity data to drive
    logic [14:0][7:0] regs; // aux, general and bank address regs
    logic carry; // carry register
    logic int_mask_bit, not_zero, user_flag, uf0, uf1, si; // writable and sampled status bits
    logic [STACK_DEPTH-1:0][12:0] stk; // return stack
    logic [SPW-1:0] sp; // entries in use
    logic nmi_prev; // last NMI level for edge detection
    logic nmi_pend; // NMI waiting for a boundary
    logic [2:0] cyc_cnt; // clocks into this cycle, for checks
  } core_t;
  core_t st_q, st_d;

  quarter_t quarter; // current quarter
  logic q_end; // last clock of current quarter
  logic slow_active; // half-rate cycle

  quarter_timer u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .half_speed_request_n(half_speed_request_n),
    .quarter(quarter),
    .q_end(q_end),
    .slow_active(slow_active)
  );

  // ==========================================================
  // helpers
  function automatic logic [7:0] rot_r(input logic [7:0] v, input logic [2:0] n);
    rot_r = 8'((v >> n) | (v << (4'h8 - {1'b0, n})));
  endfunction : rot_r

  function automatic logic [7:0] rot_l(input logic [7:0] v, input logic [2:0] n);
    rot_l = 8'((v << n) | (v >> (4'h8 - {1'b0, n})));
  endfunction : rot_l

  // active-low select for bank 1..3, all high for 0
  function automatic logic [2:0] bank_dec(input logic [1:0] b);
    bank_dec = ~(3'((b != 2'h0) ? (3'h1 << (b - 2'h1)) : 3'h0));
  endfunction : bank_dec

  // ==========================================================
  // decode of the latched instruction
  op_t op;
  logic [3:0] src, dst;
  logic [2:0] rrot, len;
  logic [1:0] io_bank;
  logic io_dir, full, empty;
  logic [7:0] status, src_v, mask, field, aux, alu, dst_old, merged, lmask;
  logic [8:0] sum;
  logic rd_io, wr_io, wr_adr, q34;
  logic [1:0] adr_bank;

  assign op = op_t'(st_q.iword[`F_OP]);
  assign src = st_q.iword[`F_SRC];
  assign dst = st_q.iword[`F_DST];
  assign rrot = st_q.iword[`F_RROT];
  assign len = st_q.iword[`F_LEN];
  assign io_bank = st_q.iword[`F_IOBANK];
  assign io_dir = st_q.iword[`F_IODIR];
  assign full = (st_q.sp == SPW'(STACK_DEPTH));
  assign empty = (st_q.sp == '0);
  assign status = {full, empty, st_q.si, st_q.uf1, st_q.uf0, st_q.user_flag, st_q.not_zero, st_q.int_mask_bit};
  assign aux = st_q.regs[0];

  // data path within one cycle: input, rotate, mask, ALU, rotate back, merge
  assign src_v = rd_io ? st_q.in_data : ((src == `REG_STATUS) ? status : st_q.regs[src]);
  assign mask = 8'((9'h2 << len) - 9'h1);
  assign field = rot_r(src_v, rrot) & mask;
  assign sum = {1'b0, field} + {1'b0, aux};
  always_comb begin
    case (op)
      OP_ADD: alu = sum[7:0];
      OP_AND: alu = field & aux;
      OP_XOR: alu = field ^ aux;
      OP_XMIT: alu = st_q.iword[`F_IMM];
      default: alu = field;
    endcase
  end
  assign lmask = (op == OP_XMIT) ? 8'hFF : rot_l(mask, rrot);
  assign dst_old = wr_io ? 8'h00 : ((dst == `REG_STATUS) ? status : st_q.regs[dst]);
  // aux as destination takes the ALU result right-justified, no merge
  assign merged = (dst == `REG_AUX && !wr_io) ? alu :
                  ((dst_old & ~lmask) | (((op == OP_XMIT) ? alu : rot_l(alu, rrot)) & lmask));

  // ==========================================================
  // bus access kinds; only one bank touched per cycle
  assign rd_io = st_q.run && io_bank != 2'h0 && !io_dir && op <= OP_XOR;
  assign wr_io = st_q.run && io_bank != 2'h0 && io_dir && op <= OP_XMIT;
  assign wr_adr = st_q.run && io_bank == 2'h0 && dst >= `REG_BANK_A && dst <= `REG_BANK_C && op <= OP_XMIT;
  assign adr_bank = 2'(dst - `REG_BANK_A + 4'h1);
  assign q34 = (quarter == Q3) || (quarter == Q4);

  // ==========================================================
  // pins
  // read uses Q2 only; output holds Q3 and Q4 so the strobe latches stable data
  always_comb begin
    bank_sel_n = 3'h7;
    if (quarter == Q2 && rd_io) begin
      bank_sel_n = bank_dec(io_bank);
    end else if (q34 && wr_io) begin
      bank_sel_n = bank_dec(io_bank);
    end else if (q34 && wr_adr) begin
      bank_sel_n = bank_dec(adr_bank);
    end
  end
  assign addr_out_flag = q34 && wr_adr;
  assign data_out_flag = q34 && wr_io;
  assign io_bus_oe = q34 && (wr_io || wr_adr);
  assign io_bus_out = st_q.out_q;
  assign master_strobe = (quarter == Q4);
  assign q34_sync_clock = q34;
  assign prog_addr = st_q.pc;
  assign user_flag_out = st_q.user_flag;
  assign result_not_zero = st_q.not_zero;
  assign intr_accept_out = !st_q.int_mask_bit && !full;
  assign carry_out_pin = st_q.carry;

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.nmi_prev = nmi_n;
    st_d.cyc_cnt = (quarter == Q1 && st_q.cyc_cnt != 3'h0 && q_end == 1'b0) ? st_q.cyc_cnt : 3'(st_q.cyc_cnt + 3'h1);
    if (q_end) begin
      case (quarter)
        Q1: begin
          st_d.iword = instr_in;
          st_d.run = halt_n;
        end
        Q2: begin
          if (rd_io) begin
            st_d.in_data = ~io_bus_in;
          end
          st_d.out_q = ~merged;
        end
        Q3: begin
          st_d.out_q = st_q.out_q;
        end
        Q4: begin
          st_d.si = si_pin;
          st_d.cyc_cnt = 3'h0;
          if (st_q.run) begin
            // writeback
            if (op <= OP_XMIT && !wr_io) begin
              if (dst == `REG_STATUS) begin
                st_d.int_mask_bit = merged[`ST_MASK];
                st_d.not_zero = merged[`ST_NOT_ZERO];
                st_d.user_flag = merged[`ST_USER_FLAG];
                st_d.uf0 = merged[`ST_UF0];
                st_d.uf1 = merged[`ST_UF1];
              end else begin
                st_d.regs[dst] = merged;
              end
            end
            if (op <= OP_XOR && dst != `REG_STATUS) begin
              st_d.not_zero = (alu != 8'h00);
            end
            if (op == OP_ADD) begin
              st_d.carry = sum[8];
            end
            // next address
            st_d.pc = 13'(st_q.pc + 13'h1);
            case (op)
              OP_JMP: st_d.pc = st_q.iword[`F_JADDR];
              OP_CALL: begin
                if (!full) begin
                  st_d.stk[st_q.sp] = 13'(st_q.pc + 13'h1);
                  st_d.sp = SPW'(st_q.sp + 1'b1);
                end
                st_d.pc = st_q.iword[`F_JADDR];
              end
              OP_RET: begin
                if (!empty) begin
                  st_d.pc = st_q.stk[SPW'(st_q.sp - 1'b1)];
                  st_d.sp = SPW'(st_q.sp - 1'b1);
                end
              end
              default: st_d.pc = 13'(st_q.pc + 13'h1);
            endcase
            // interrupts only at the boundary of an executed cycle
            if (st_q.nmi_pend || (!int_n && !st_q.int_mask_bit && !full)) begin
              if (st_d.sp != SPW'(STACK_DEPTH)) begin
                st_d.stk[st_d.sp] = st_d.pc;
                st_d.sp = SPW'(st_d.sp + 1'b1);
              end
              st_d.pc = st_q.nmi_pend ? `NMI_VEC : `INT_VEC;
              st_d.int_mask_bit = 1'b1;
              st_d.nmi_pend = 1'b0;
            end
          end
        end
        default: st_d.run = 1'b0;
      endcase
    end
    // a new edge wins over the clear of the boundary above
    if (st_q.nmi_prev && !nmi_n) begin
      st_d.nmi_pend = 1'b1;
    end
  end

  // state register; reset parks pc at zero and blocks bus activity
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.int_mask_bit <= 1'b1;
      st_q.nmi_prev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_halt_seen;
    quarter == Q1 && q_end && !halt_n;
  endsequence
  sequence s_int_taken;
    quarter == Q4 && q_end && st_q.run && !st_q.nmi_pend && !int_n && !st_q.int_mask_bit && !full;
  endsequence

  AST_ONE_BANK: assert property ($onehot0(~bank_sel_n))
    else $error("more than one bank selected");
  AST_FLOAT: assert property (&bank_sel_n |-> !io_bus_oe && !addr_out_flag && !data_out_flag)
    else $error("bus driven with no bank");
  AST_FLAGS: assert property (!(addr_out_flag && data_out_flag))
    else $error("both bus flags high");
  AST_STROBE: assert property ((quarter == Q3 && q_end) |=> master_strobe && q34_sync_clock)
    else $error("strobe missing in Q4");
  AST_SYNC: assert property ((quarter == Q2 && q_end) |=> q34_sync_clock && !master_strobe)
    else $error("sync clock wrong in Q3");
  // reset is the trigger here, so the default reset disable must not switch this check off
  AST_RESET: assert property (@(posedge core_clk) disable iff (1'b0)
    reset |=> prog_addr == 13'h0000 && &bank_sel_n && !io_bus_oe)
    else $error("reset did not park pins");
  AST_HALT: assert property (s_halt_seen |=> !st_q.run ##0 ($stable(prog_addr) && &bank_sel_n) [*3])
    else $error("halted cycle ran");
  AST_NMI: assert property ($fell(nmi_n) |=> st_q.nmi_pend)
    else $error("nmi edge lost");
  AST_INT: assert property (s_int_taken |=> prog_addr == `INT_VEC && st_q.int_mask_bit && st_q.sp != '0)
    else $error("interrupt not vectored");
  AST_SI: assert property ((quarter == Q4 && q_end) |=> st_q.si == $past(si_pin))
    else $error("status input not sampled");
  AST_ACCEPT: assert property (intr_accept_out == (!status[`ST_MASK] && !status[`ST_STK_FULL]))
    else $error("accept pin mismatch");
  AST_CYCLE: assert property ((quarter == Q4 && q_end) |-> 4'(st_q.cyc_cnt) + 4'h1 >= 4'(`CYC_MIN_CLKS))
    else $error("cycle shorter than minimum");
endmodule : cycle_pin_core

// *** prog_io_model.sv ***
// Purpose: program store and banked peripherals facing the cycle core
// Assumes: pin-level bus with active-low data; bank_sel_n [0]=A [1]=B [2]=C
// Notes: with nobody driving, the bus shows a pattern that flips every clock
`timescale 1ns/1ns
module prog_io_model (
  input wire logic core_clk,
  input wire logic [12:0] prog_addr,
  output logic [19:0] instr_in,
  input wire logic [2:0] bank_sel_n,
  input wire logic addr_out_flag,
  input wire logic data_out_flag,
  input wire logic master_strobe,
  input wire logic [7:0] io_bus_out,
  input wire logic io_bus_oe,
  output logic [7:0] io_bus_in
);
  // ==========================================================
  // storage
  logic [19:0] rom [0:8191]; // program words, filled by the bench
  logic [7:0] read_val = 8'h96; // what a peripheral returns on a read
  logic [7:0] last_addr = 8'h00; // last latched address, true polarity
  logic [7:0] last_data = 8'h00; // last latched data, true polarity
  logic [7:0] noise = 8'h55; // floating lines, so a stale value never passes
  logic reading; // a bank selected with both qualifiers low
  // ==========================================================
  // answers
  assign instr_in = rom[prog_addr];
  assign reading = (bank_sel_n != 3'b111) && !addr_out_flag && !data_out_flag;
  // wire level: device when enabled, peripheral on a read, else floating
  assign io_bus_in = io_bus_oe ? io_bus_out : (reading ? ~read_val : noise);
  // peripherals latch on the strobe, undoing the bus inversion
  always @(posedge core_clk) begin
    noise <= ~noise;
    if (master_strobe && addr_out_flag) begin
      last_addr <= ~io_bus_in;
    end
    if (master_strobe && data_out_flag) begin
      last_data <= ~io_bus_in;
    end
  end
endmodule : prog_io_model

// *** quarter_timer.sv ***
// Purpose: steps the four quarters of each instruction cycle
// Assumes: core_clk is the base clock; reset synchronous, active high
// Notes: a slow request stretches every quarter of that cycle to two clocks
`timescale 1ns/1ns
module quarter_timer
  import cyc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic half_speed_request_n,
  output quarter_t quarter,
  output logic q_end,
  output logic slow_active
);
  // ==========================================================
  // state
  typedef struct packed {
    quarter_t q; // current quarter
    logic sub; // second clock of a stretched quarter
    logic slow; // this cycle runs at half rate
  } tmr_t;
  tmr_t st_q, st_d;
  logic slow_eff; // slow decision, live in the first clock of Q1

  // slow request is taken in the first clock of Q1 and held for the cycle
  assign slow_eff = (st_q.q == Q1 && !st_q.sub) ? !half_speed_request_n : st_q.slow;
  assign q_end = !slow_eff || st_q.sub;
  assign quarter = st_q.q;
  assign slow_active = slow_eff;

  // next state
  always_comb begin
    st_d = st_q;
    st_d.slow = slow_eff;
    if (q_end) begin
      st_d.sub = 1'b0;
      case (st_q.q)
        Q1: st_d.q = Q2;
        Q2: st_d.q = Q3;
        Q3: st_d.q = Q4;
        Q4: st_d.q = Q1;
        default: st_d.q = Q1;
      endcase
    end else begin
      st_d.sub = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // checks
  sequence s_slow_q1;
    st_q.q == Q1 && !st_q.sub && !half_speed_request_n;
  endsequence
  AST_SLOW_Q1: assert property (@(posedge core_clk) disable iff (reset)
    s_slow_q1 |=> st_q.q == Q1 ##1 st_q.q == Q2 ##1 st_q.q == Q2 ##1 st_q.q == Q3)
    else $error("slow cycle did not stretch quarters");
  AST_FAST_Q: assert property (@(posedge core_clk) disable iff (reset)
    (st_q.q == Q1 && !st_q.sub && half_speed_request_n) |=> st_q.q == Q2 ##1 st_q.q == Q3 ##1 st_q.q == Q4)
    else $error("normal quarter not one clock");
endmodule : quarter_timer
